// >>> sdc_pkg.sv
// Register map, field positions and carriers for the sync/detect block
package sdc_pkg;
	localparam logic [12:0] ADDR_SYNC = 13'h100;
	localparam logic [12:0] ADDR_MIX = 13'h101;
	localparam logic [12:0] ADDR_FIR = 13'h102;
	localparam logic [12:0] ADDR_HB = 13'h103;
	localparam logic [12:0] ADDR_OFL = 13'h104;
	localparam logic [12:0] ADDR_CRS = 13'h105;
	localparam logic [12:0] ADDR_FHL = 13'h106;
	localparam logic [12:0] ADDR_FHH = 13'h107;
	localparam logic [12:0] ADDR_FLL = 13'h108;
	localparam logic [12:0] ADDR_FLH = 13'h109;
	localparam logic [12:0] ADDR_DWL = 13'h10A;
	localparam logic [12:0] ADDR_DWH = 13'h10B;
	localparam logic [12:0] ADDR_DCC = 13'h10C;
	localparam logic [12:0] ADDR_DCL = 13'h10D;
	localparam logic [12:0] ADDR_DCH = 13'h10E;
	localparam int SYNC_MASTER = 0;
	localparam int SYNC_DIV = 1;
	localparam int SYNC_DIV_ONE = 2;
	localparam int SYNC_OSC = 3;
	localparam int SYNC_OSC_ONE = 4;
	localparam int SYNC_HB = 5;
	localparam int SYNC_HB_ONE = 6;
	localparam int SYNC_MON = 7;
	localparam int MIX_EN = 0;
	localparam int MIX_ONE = 1;
	localparam int MIX_START = 4;
	localparam int FIR_EN = 0;
	localparam int FIR_CPLX = 1;
	localparam int FIR_MIXOFF = 2;
	localparam int FIR_GAIN = 3;
	localparam int HB_HIPASS = 1;
	localparam int HB_REV = 2;
	localparam int HB_PHASE = 3;
	localparam int OFL_EN = 0;
	localparam int OFL_MODE = 1;
	localparam int DC_MON = 0;
	localparam int DC_PATH = 1;
	localparam int DC_K = 2;
	localparam int DC_FREEZE = 6;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] MASK_MIX = 8'h33;
	localparam logic [7:0] MASK_FIR = 8'h0F;
	localparam logic [7:0] MASK_HB = 8'h0E;
	localparam logic [7:0] HB_FIXED_ONE = 8'h01;
	localparam logic [7:0] MASK_OFL = 8'h0F;
	localparam logic [7:0] MASK_CRS = 8'h07;
	localparam logic [7:0] MASK_HI5 = 8'h1F;
	localparam logic [7:0] MASK_DCC = 8'h7F;
	localparam logic [3:0] K_MAX = 4'hD;
	typedef struct packed {
		logic fir_en;
		logic cplx_out;
		logic mixer_off;
		logic fir_gain_one;
		logic hb_alt_phase;
		logic hb_reverse;
		logic hb_highpass;
		logic [1:0] mix_start;
		logic [2:0] ofl_mode;
		logic dc_mon_en;
		logic dc_path_en;
	} sdc_cfg_t;
	typedef struct packed {
		logic monitor;
		logic halfband;
		logic oscillator;
		logic divider;
		logic mixer;
	} sdc_sync_t;
	typedef struct packed {
		logic raise_gain_flag;
		logic fine_low_flag;
		logic fine_high_flag;
		logic coarse_flag;
	} sdc_flags_t;
endpackage

// >>> sdc_thresh.sv
// Fast detect thresholds and dwell timing for one channel
`timescale 1ns/1ps
module sdc_thresh #(
	parameter int MW = 13,
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Sample stream
	input wire logic samp_tick,
	input wire logic [MW-1:0] mag,
	// Limits
	input wire logic [2:0] coarse_lim,
	input wire logic [MW-1:0] hi_lim,
	input wire logic [MW-1:0] lo_lim,
	input wire logic [DW-1:0] dwell,
	// Flags
	output sdc_pkg::sdc_flags_t flags
);
	logic [DW-1:0] cnt_r;
	logic [DW-1:0] cnt_nxt;
	sdc_pkg::sdc_flags_t flags_r;
	sdc_pkg::sdc_flags_t flags_nxt;
	logic below;

	always_comb begin
		below = mag < lo_lim;
		cnt_nxt = cnt_r;
		flags_nxt = flags_r;
		if (samp_tick) begin
			// Saturating run length of low samples
			if (!below)
				cnt_nxt = '0;
			else if (cnt_r != {DW{1'b1}})
				cnt_nxt = cnt_r + 1'b1;
			flags_nxt.coarse_flag = mag[MW-1 -: 3] > coarse_lim;
			flags_nxt.fine_high_flag = mag > hi_lim;
			flags_nxt.fine_low_flag = below && cnt_nxt >= dwell;
			flags_nxt.raise_gain_flag = below && cnt_nxt >= dwell;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cnt_r <= '0;
			flags_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;

	dwell_hold_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		$rose(flags_r.fine_low_flag) |-> cnt_r >= $past(dwell))
		else $error("fine low flag before dwell elapsed");
endmodule // sdc_thresh

// >>> sdc_dcest.sv
// Running dc offset estimator with freeze and path removal
`timescale 1ns/1ps
module sdc_dcest #(
	parameter int DW = 14
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Sample stream
	input wire logic samp_tick,
	input wire logic signed [DW-1:0] samp,
	// Control
	input wire logic [3:0] k_sel,
	input wire logic freeze,
	input wire logic path_en,
	// Results
	output logic signed [DW-1:0] est,
	output logic signed [DW-1:0] corr
);
	localparam int AW = 2 * DW;
	logic signed [AW-1:0] acc_r;
	logic signed [AW-1:0] acc_nxt;
	logic signed [DW-1:0] corr_r;
	logic signed [DW-1:0] corr_nxt;
	logic signed [AW:0] diff;
	logic [3:0] k_eff;

	always_comb begin
		k_eff = (k_sel > sdc_pkg::K_MAX) ? sdc_pkg::K_MAX : k_sel;
		diff = {samp[DW-1], samp, {DW{1'b0}}} - {acc_r[AW-1], acc_r};
		acc_nxt = acc_r;
		corr_nxt = corr_r;
		if (samp_tick) begin
			if (!freeze)
				acc_nxt = acc_r + AW'(diff >>> k_eff);
			// Offset removed by adding the negated estimate
			corr_nxt = path_en ? DW'(samp - acc_r[AW-1 -: DW]) : samp;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_r <= '0;
			corr_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			corr_r <= corr_nxt;
		end
	end

	assign est = acc_r[AW-1 -: DW];
	assign corr = corr_r;

	freeze_hold_a: assert property (@(posedge core_clk)
		disable iff (!resetn) freeze |=> $stable(acc_r))
		else $error("estimate moved while frozen");
endmodule // sdc_dcest

// >>> sdc_ctrl.sv
// Sync gating, filter and output configuration, fast detect and dc readback
`timescale 1ns/1ps
module sdc_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Register port from the serial controller
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [12:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// External sync pin
	input wire logic sync_pin,
	// Sample path, divided-clock strobe
	input wire logic samp_tick,
	input wire logic [12:0] mag_a,
	input wire logic [12:0] mag_b,
	input wire logic signed [13:0] samp_a,
	// Output mode status
	input wire logic lvds_ilv,
	input wire logic chan_a_on,
	input wire logic chan_b_on,
	// Gated sync pulses and configuration
	output sdc_pkg::sdc_sync_t sync_out,
	output sdc_pkg::sdc_cfg_t cfg_out,
	// Fast detect pins
	output sdc_pkg::sdc_flags_t overrange_flag_outputs,
	output logic overrange_flag_oe,
	// Offset-corrected channel A data
	output logic signed [13:0] corr_a
);
	logic [7:0] sync_r;
	logic [7:0] sync_nxt;
	logic [7:0] mix_r;
	logic [7:0] mix_nxt;
	logic [7:0] fir_r;
	logic [7:0] fir_nxt;
	logic [7:0] hb_r;
	logic [7:0] hb_nxt;
	logic [7:0] ofl_r;
	logic [7:0] ofl_nxt;
	logic [7:0] crs_r;
	logic [7:0] crs_nxt;
	logic [7:0] fhl_r;
	logic [7:0] fhl_nxt;
	logic [7:0] fhh_r;
	logic [7:0] fhh_nxt;
	logic [7:0] fll_r;
	logic [7:0] fll_nxt;
	logic [7:0] flh_r;
	logic [7:0] flh_nxt;
	logic [7:0] dwl_r;
	logic [7:0] dwl_nxt;
	logic [7:0] dwh_r;
	logic [7:0] dwh_nxt;
	logic [7:0] dcc_r;
	logic [7:0] dcc_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic sp1_r;
	logic sp2_r;
	logic sp3_r;
	logic pulse;
	logic master;
	sdc_pkg::sdc_sync_t go;
	sdc_pkg::sdc_sync_t sync_out_r;
	sdc_pkg::sdc_cfg_t cfg;
	sdc_pkg::sdc_flags_t flags_a;
	sdc_pkg::sdc_flags_t flags_b;
	sdc_pkg::sdc_flags_t ofl_out_r;
	sdc_pkg::sdc_flags_t ofl_out_nxt;
	logic ofl_oe_r;
	logic ofl_oe_nxt;
	logic alt_r;
	logic signed [13:0] est_a;

	// Readback mux, reserved bits zero, half-band bit 0 reads one
	function automatic logic [7:0] rd_mux(input logic [12:0] a,
		input logic signed [13:0] e);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			sdc_pkg::ADDR_SYNC: v = sync_r;
			sdc_pkg::ADDR_MIX: v = mix_r;
			sdc_pkg::ADDR_FIR: v = fir_r;
			sdc_pkg::ADDR_HB: v = hb_r | sdc_pkg::HB_FIXED_ONE;
			sdc_pkg::ADDR_OFL: v = ofl_r;
			sdc_pkg::ADDR_CRS: v = crs_r;
			sdc_pkg::ADDR_FHL: v = fhl_r;
			sdc_pkg::ADDR_FHH: v = fhh_r;
			sdc_pkg::ADDR_FLL: v = fll_r;
			sdc_pkg::ADDR_FLH: v = flh_r;
			sdc_pkg::ADDR_DWL: v = dwl_r;
			sdc_pkg::ADDR_DWH: v = dwh_r;
			sdc_pkg::ADDR_DCC: v = dcc_r;
			sdc_pkg::ADDR_DCL: v = e[7:0];
			sdc_pkg::ADDR_DCH: v = {2'b00, e[13:8]};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Sync pin: two-stage synchroniser, then rising edge
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sp1_r <= 1'b0;
			sp2_r <= 1'b0;
			sp3_r <= 1'b0;
		end else begin
			sp1_r <= sync_pin;
			sp2_r <= sp1_r;
			sp3_r <= sp2_r;
		end
	end

	always_comb begin
		pulse = sp2_r && !sp3_r;
		master = sync_r[sdc_pkg::SYNC_MASTER];
		go.monitor = pulse && master && sync_r[sdc_pkg::SYNC_MON];
		go.halfband = pulse && master && sync_r[sdc_pkg::SYNC_HB];
		go.oscillator = pulse && master && sync_r[sdc_pkg::SYNC_OSC];
		go.divider = pulse && master && sync_r[sdc_pkg::SYNC_DIV];
		go.mixer = pulse && master && mix_r[sdc_pkg::MIX_EN];
	end

	// Register writes; a software write wins over a one-shot clear
	always_comb begin
		sync_nxt = sync_r;
		mix_nxt = mix_r;
		fir_nxt = fir_r;
		hb_nxt = hb_r;
		ofl_nxt = ofl_r;
		crs_nxt = crs_r;
		fhl_nxt = fhl_r;
		fhh_nxt = fhh_r;
		fll_nxt = fll_r;
		flh_nxt = flh_r;
		dwl_nxt = dwl_r;
		dwh_nxt = dwh_r;
		dcc_nxt = dcc_r;
		if (go.halfband && sync_r[sdc_pkg::SYNC_HB_ONE])
			sync_nxt[sdc_pkg::SYNC_HB] = 1'b0;
		if (go.oscillator && sync_r[sdc_pkg::SYNC_OSC_ONE])
			sync_nxt[sdc_pkg::SYNC_OSC] = 1'b0;
		if (go.divider && sync_r[sdc_pkg::SYNC_DIV_ONE])
			sync_nxt[sdc_pkg::SYNC_DIV] = 1'b0;
		if (go.mixer && mix_r[sdc_pkg::MIX_ONE])
			mix_nxt[sdc_pkg::MIX_EN] = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				sdc_pkg::ADDR_SYNC: sync_nxt = reg_wdata;
				sdc_pkg::ADDR_MIX: mix_nxt = reg_wdata & sdc_pkg::MASK_MIX;
				sdc_pkg::ADDR_FIR: fir_nxt = reg_wdata & sdc_pkg::MASK_FIR;
				sdc_pkg::ADDR_HB: hb_nxt = reg_wdata & sdc_pkg::MASK_HB;
				sdc_pkg::ADDR_OFL: ofl_nxt = reg_wdata & sdc_pkg::MASK_OFL;
				sdc_pkg::ADDR_CRS: crs_nxt = reg_wdata & sdc_pkg::MASK_CRS;
				sdc_pkg::ADDR_FHL: fhl_nxt = reg_wdata;
				sdc_pkg::ADDR_FHH: fhh_nxt = reg_wdata & sdc_pkg::MASK_HI5;
				sdc_pkg::ADDR_FLL: fll_nxt = reg_wdata;
				sdc_pkg::ADDR_FLH: flh_nxt = reg_wdata & sdc_pkg::MASK_HI5;
				sdc_pkg::ADDR_DWL: dwl_nxt = reg_wdata;
				sdc_pkg::ADDR_DWH: dwh_nxt = reg_wdata;
				sdc_pkg::ADDR_DCC: dcc_nxt = reg_wdata & sdc_pkg::MASK_DCC;
				default: ;
			endcase
		end
		rdata_nxt = reg_rd ? rd_mux(reg_addr, est_a) : rdata_r;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sync_r <= sdc_pkg::REG_RST;
			mix_r <= sdc_pkg::REG_RST;
			fir_r <= sdc_pkg::REG_RST;
			hb_r <= sdc_pkg::REG_RST;
			ofl_r <= sdc_pkg::REG_RST;
			crs_r <= sdc_pkg::REG_RST;
			fhl_r <= sdc_pkg::REG_RST;
			fhh_r <= sdc_pkg::REG_RST;
			fll_r <= sdc_pkg::REG_RST;
			flh_r <= sdc_pkg::REG_RST;
			dwl_r <= sdc_pkg::REG_RST;
			dwh_r <= sdc_pkg::REG_RST;
			dcc_r <= sdc_pkg::REG_RST;
			rdata_r <= sdc_pkg::REG_RST;
		end else begin
			sync_r <= sync_nxt;
			mix_r <= mix_nxt;
			fir_r <= fir_nxt;
			hb_r <= hb_nxt;
			ofl_r <= ofl_nxt;
			crs_r <= crs_nxt;
			fhl_r <= fhl_nxt;
			fhh_r <= fhh_nxt;
			fll_r <= fll_nxt;
			flh_r <= flh_nxt;
			dwl_r <= dwl_nxt;
			dwh_r <= dwh_nxt;
			dcc_r <= dcc_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Configuration view of the control registers
	always_comb begin
		cfg.fir_en = fir_r[sdc_pkg::FIR_EN];
		cfg.cplx_out = fir_r[sdc_pkg::FIR_CPLX];
		cfg.mixer_off = fir_r[sdc_pkg::FIR_MIXOFF];
		cfg.fir_gain_one = fir_r[sdc_pkg::FIR_GAIN];
		cfg.hb_alt_phase = hb_r[sdc_pkg::HB_PHASE];
		cfg.hb_reverse = hb_r[sdc_pkg::HB_REV];
		cfg.hb_highpass = hb_r[sdc_pkg::HB_HIPASS];
		cfg.mix_start = mix_r[sdc_pkg::MIX_START +: 2];
		cfg.ofl_mode = ofl_r[sdc_pkg::OFL_MODE +: 3];
		cfg.dc_mon_en = dcc_r[sdc_pkg::DC_MON];
		cfg.dc_path_en = dcc_r[sdc_pkg::DC_PATH];
	end

	sdc_thresh #(.MW(13), .DW(16)) u_thr_a (
		.core_clk(core_clk),
		.resetn(resetn),
		.samp_tick(samp_tick),
		.mag(mag_a),
		.coarse_lim(crs_r[2:0]),
		.hi_lim({fhh_r[4:0], fhl_r}),
		.lo_lim({flh_r[4:0], fll_r}),
		.dwell({dwh_r, dwl_r}),
		.flags(flags_a)
	);

	sdc_thresh #(.MW(13), .DW(16)) u_thr_b (
		.core_clk(core_clk),
		.resetn(resetn),
		.samp_tick(samp_tick),
		.mag(mag_b),
		.coarse_lim(crs_r[2:0]),
		.hi_lim({fhh_r[4:0], fhl_r}),
		.lo_lim({flh_r[4:0], fll_r}),
		.dwell({dwh_r, dwl_r}),
		.flags(flags_b)
	);

	sdc_dcest #(.DW(14)) u_dc_a (
		.core_clk(core_clk),
		.resetn(resetn),
		.samp_tick(samp_tick),
		.samp(samp_a),
		.k_sel(dcc_r[sdc_pkg::DC_K +: 4]),
		.freeze(dcc_r[sdc_pkg::DC_FREEZE]),
		.path_en(dcc_r[sdc_pkg::DC_PATH]),
		.est(est_a),
		.corr(corr_a)
	);

	// Fast detect pins; interleaved mode alternates channels when both are on
	always_comb begin
		ofl_out_nxt = flags_a;
		ofl_oe_nxt = ofl_r[sdc_pkg::OFL_EN];
		if (lvds_ilv) begin
			ofl_oe_nxt = ofl_r[sdc_pkg::OFL_EN] &&
				(chan_a_on || chan_b_on);
			if (!chan_a_on || (chan_b_on && alt_r))
				ofl_out_nxt = flags_b;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ofl_out_r <= '0;
			ofl_oe_r <= 1'b0;
			alt_r <= 1'b0;
			sync_out_r <= '0;
		end else begin
			ofl_out_r <= ofl_out_nxt;
			ofl_oe_r <= ofl_oe_nxt;
			alt_r <= !alt_r;
			sync_out_r <= go;
		end
	end

	assign reg_rdata = rdata_r;
	assign sync_out = sync_out_r;
	assign cfg_out = cfg;
	assign overrange_flag_outputs = ofl_out_r;
	assign overrange_flag_oe = ofl_oe_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence hb_shot_s;
		go.halfband && sync_r[sdc_pkg::SYNC_HB_ONE] && !reg_wr;
	endsequence
	sequence osc_shot_s;
		go.oscillator && sync_r[sdc_pkg::SYNC_OSC_ONE] && !reg_wr;
	endsequence
	sequence mix_shot_s;
		go.mixer && mix_r[sdc_pkg::MIX_ONE] && !reg_wr;
	endsequence
	sequence div_shot_s;
		go.divider && sync_r[sdc_pkg::SYNC_DIV_ONE] && !reg_wr;
	endsequence

	master_gate_a: assert property (!sync_r[sdc_pkg::SYNC_MASTER] |=>
		sync_out_r == '0) else $error("sync passed without master");
	mon_pass_a: assert property (pulse && sync_r[sdc_pkg::SYNC_MASTER] &&
		sync_r[sdc_pkg::SYNC_MON] |=> sync_out_r.monitor)
		else $error("monitor sync not passed");
	hb_oneshot_a: assert property (hb_shot_s |=>
		sync_out_r.halfband && !sync_r[sdc_pkg::SYNC_HB])
		else $error("half-band one-shot not cleared");
	osc_oneshot_a: assert property (osc_shot_s |=>
		sync_out_r.oscillator && !sync_r[sdc_pkg::SYNC_OSC])
		else $error("oscillator one-shot not cleared");
	osc_cont_a: assert property (go.oscillator && !reg_wr &&
		!sync_r[sdc_pkg::SYNC_OSC_ONE] |=> sync_r[sdc_pkg::SYNC_OSC])
		else $error("oscillator enable lost in continuous mode");
	div_pass_a: assert property (sync_out_r.divider |->
		$past(sync_r[sdc_pkg::SYNC_DIV]) && $past(pulse))
		else $error("divider sync without enable");
	mix_oneshot_a: assert property (mix_shot_s |=>
		sync_out_r.mixer && !mix_r[sdc_pkg::MIX_EN])
		else $error("mixer one-shot not cleared");
	mix_pass_a: assert property (pulse && sync_r[sdc_pkg::SYNC_MASTER] &&
		mix_r[sdc_pkg::MIX_EN] |=> sync_out_r.mixer)
		else $error("mixer sync not passed");
	ofl_hiz_a: assert property (!ofl_r[sdc_pkg::OFL_EN] |=>
		!overrange_flag_oe) else $error("flag pins driven while off");
	ilv_hiz_a: assert property (lvds_ilv && !chan_a_on &&
		!chan_b_on |=> !overrange_flag_oe)
		else $error("flag pins driven with both channels off");
	ilv_follow_a: assert property (lvds_ilv && !chan_a_on |=>
		overrange_flag_outputs == $past(flags_b))
		else $error("flag pins not following channel B");
	hb_pass_a: assert property (pulse && sync_r[sdc_pkg::SYNC_MASTER] &&
		sync_r[sdc_pkg::SYNC_HB] |=> sync_out_r.halfband)
		else $error("half-band sync not passed");
	div_oneshot_a: assert property (div_shot_s |=>
		sync_out_r.divider && !sync_r[sdc_pkg::SYNC_DIV])
		else $error("divider one-shot not cleared");
	coarse_wr_a: assert property (reg_wr &&
		reg_addr == sdc_pkg::ADDR_CRS |=>
		crs_r[2:0] == $past(reg_wdata[2:0]))
		else $error("coarse threshold write lost");
endmodule // sdc_ctrl

// >>> sdc_host.sv
// Host side model: register port master and external sync source
`timescale 1ns/1ps
module sdc_host (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [12:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Sync source
	output logic sync_pin
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 13'h0000;
		reg_wdata = 8'h00;
		sync_pin = 1'b0;
	end
	// Idle lines show the inverse so stale values never look valid
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [12:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge core_clk);
		#1;
		d = reg_rdata;
	endtask
	// Pin held high and low well beyond the two-cycle minimum
	task automatic pulse();
		@(posedge core_clk);
		#1;
		sync_pin = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		sync_pin = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
endmodule // sdc_host

// >>> test_sdc_ctrl.sv
// Self-checking bench for the sync/detect control block
`timescale 1ns/1ps
module test_sdc_ctrl;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr, reg_rd, sync_pin;
	logic [12:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic samp_tick = 1'b0;
	logic [12:0] mag_a = 13'h0000;
	logic [12:0] mag_b = 13'h0000;
	logic signed [13:0] samp_a = 14'h0000;
	logic lvds_ilv = 1'b0;
	logic chan_a_on = 1'b1;
	logic chan_b_on = 1'b1;
	sdc_pkg::sdc_sync_t sync_out;
	sdc_pkg::sdc_cfg_t cfg_out, ecfg;
	sdc_pkg::sdc_flags_t overrange_flag_outputs, fl_prev;
	logic overrange_flag_oe;
	logic signed [13:0] corr_a;
	logic [7:0] msk [15] = '{8'hFF, 8'h33, 8'h0F, 8'h0F, 8'h0F, 8'h07,
		8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h00};
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int cnt [5];
	always #10 core_clk = ~core_clk;
	sdc_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sync_pin(sync_pin));
	sdc_ctrl uut (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sync_pin(sync_pin),
		.samp_tick(samp_tick), .mag_a(mag_a), .mag_b(mag_b),
		.samp_a(samp_a), .lvds_ilv(lvds_ilv), .chan_a_on(chan_a_on),
		.chan_b_on(chan_b_on), .sync_out(sync_out), .cfg_out(cfg_out),
		.overrange_flag_outputs(overrange_flag_outputs),
		.overrange_flag_oe(overrange_flag_oe), .corr_a(corr_a));
	// Pulse counters per sync target, index 4 is the monitor
	always @(posedge core_clk) begin
		cyc++;
		for (int i = 0; i < 5; i++) begin
			if (sync_out[i] === 1'b1) cnt[i]++;
		end
		if (cyc > 4000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk_reg(input string n, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_val(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk_reg($sformatf("reg %h", a), e, d);
	endtask
	task automatic chk_sync(input int m, h, o, v, x);
		chk_val("monitor syncs", 16'(m), 16'(cnt[4]));
		chk_val("halfband syncs", 16'(h), 16'(cnt[3]));
		chk_val("oscillator syncs", 16'(o), 16'(cnt[2]));
		chk_val("divider syncs", 16'(v), 16'(cnt[1]));
		chk_val("mixer syncs", 16'(x), 16'(cnt[0]));
		for (int i = 0; i < 5; i++) cnt[i] = 0;
	endtask
	// One sample strobe, then settle until the pins have updated
	task automatic tick(input logic [12:0] ma, input logic [12:0] mb,
		input logic signed [13:0] s);
		@(posedge core_clk);
		#1;
		samp_tick = 1'b1;
		mag_a = ma;
		mag_b = mb;
		samp_a = s;
		@(posedge core_clk);
		#1;
		samp_tick = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic end_test(input string n);
		$display("Test %s done", n);
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 5; i++) cnt[i] = 0;
		repeat (3) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		for (int i = 0; i < 15; i++) begin
			rd_chk(13'h100 + 13'(i), (i == 3) ? 8'h01 : 8'h00);
		end
		rd_chk(13'h0FF, 8'h00);
		end_test("reset values");
		for (int i = 0; i < 15; i++) host.wr(13'h100 + 13'(i), 8'hFF);
		host.wr(13'h10F, 8'hFF);
		for (int i = 0; i < 15; i++) rd_chk(13'h100 + 13'(i), msk[i]);
		rd_chk(13'h10F, 8'h00);
		end_test("access masks");
		host.wr(13'h102, 8'h06);
		host.wr(13'h103, 8'h0A);
		host.wr(13'h101, 8'h20);
		host.wr(13'h104, 8'h06);
		host.wr(13'h10C, 8'h03);
		ecfg = '0;
		ecfg.cplx_out = 1'b1;
		ecfg.mixer_off = 1'b1;
		ecfg.hb_alt_phase = 1'b1;
		ecfg.hb_highpass = 1'b1;
		ecfg.mix_start = 2'h2;
		ecfg.ofl_mode = 3'h3;
		ecfg.dc_mon_en = 1'b1;
		ecfg.dc_path_en = 1'b1;
		chk_val("cfg_out", 16'(ecfg), 16'(cfg_out));
		host.wr(13'h102, 8'h09);
		host.wr(13'h103, 8'h04);
		ecfg = '0;
		ecfg.fir_en = 1'b1;
		ecfg.fir_gain_one = 1'b1;
		ecfg.hb_reverse = 1'b1;
		ecfg.mix_start = 2'h2;
		ecfg.ofl_mode = 3'h3;
		ecfg.dc_mon_en = 1'b1;
		ecfg.dc_path_en = 1'b1;
		chk_val("cfg_out", 16'(ecfg), 16'(cfg_out));
		end_test("configuration");
		for (int i = 0; i < 5; i++) cnt[i] = 0;
		host.wr(13'h100, 8'hAA);
		host.wr(13'h101, 8'h01);
		host.pulse();
		chk_sync(0, 0, 0, 0, 0);
		host.wr(13'h100, 8'hAB);
		host.pulse();
		host.pulse();
		chk_sync(2, 2, 2, 2, 2);
		host.wr(13'h100, 8'hFF);
		host.wr(13'h101, 8'h03);
		host.pulse();
		host.pulse();
		chk_sync(2, 1, 1, 1, 1);
		rd_chk(13'h100, 8'hD5);
		rd_chk(13'h101, 8'h02);
		end_test("sync gating");
		host.wr(13'h100, 8'h00);
		host.wr(13'h105, 8'h03);
		host.wr(13'h106, 8'h00);
		host.wr(13'h107, 8'h08);
		host.wr(13'h108, 8'h00);
		host.wr(13'h109, 8'h01);
		host.wr(13'h10A, 8'h03);
		host.wr(13'h10B, 8'h00);
		host.wr(13'h104, 8'h01);
		tick(13'h1000, 13'h1000, 14'h0000);
		chk_val("flags", 16'h0003, 16'(overrange_flag_outputs));
		chk_val("flag oe", 16'h0001, 16'(overrange_flag_oe));
		for (int i = 1; i <= 3; i++) begin
			tick(13'h0080, 13'h0080, 14'h0000);
			chk_val("flags", (i == 3) ? 16'h000C : 16'h0000,
				16'(overrange_flag_outputs));
		end
		host.wr(13'h104, 8'h00);
		repeat (3) @(posedge core_clk);
		#1;
		chk_val("flag oe", 16'h0000, 16'(overrange_flag_oe));
		lvds_ilv = 1'b1;
		chan_a_on = 1'b0;
		chan_b_on = 1'b0;
		host.wr(13'h104, 8'h01);
		repeat (3) @(posedge core_clk);
		#1;
		chk_val("flag oe", 16'h0000, 16'(overrange_flag_oe));
		chan_b_on = 1'b1;
		tick(13'h1000, 13'h0400, 14'h0000);
		chk_val("flag oe", 16'h0001, 16'(overrange_flag_oe));
		chk_val("flags", 16'h0000, 16'(overrange_flag_outputs));
		chan_a_on = 1'b1;
		chan_b_on = 1'b0;
		tick(13'h1000, 13'h0400, 14'h0000);
		chk_val("flags", 16'h0003, 16'(overrange_flag_outputs));
		// Both channels on: pins alternate between A and B flags
		chan_b_on = 1'b1;
		@(posedge core_clk);
		#1;
		fl_prev = overrange_flag_outputs;
		@(posedge core_clk);
		#1;
		chk_val("flags alternate", 16'h0003,
			16'(fl_prev ^ overrange_flag_outputs));
		lvds_ilv = 1'b0;
		chan_b_on = 1'b1;
		end_test("fast detect");
		host.wr(13'h10C, 8'h02);
		tick(13'h0000, 13'h0000, -14'sd200);
		tick(13'h0000, 13'h0000, -14'sd200);
		rd_chk(13'h10D, 8'h38);
		rd_chk(13'h10E, 8'h3F);
		chk_val("corr_a", 16'h0000, 16'(corr_a));
		host.wr(13'h10C, 8'h42);
		tick(13'h0000, 13'h0000, 14'sd50);
		rd_chk(13'h10D, 8'h38);
		chk_val("corr_a", 16'h00FA, 16'(corr_a));
		host.wr(13'h10C, 8'h40);
		tick(13'h0000, 13'h0000, 14'sd50);
		chk_val("corr_a", 16'h0032, 16'(corr_a));
		// Bandwidth 15 must behave as 13: estimate moves by one step
		host.wr(13'h10C, 8'h3C);
		tick(13'h0000, 13'h0000, 14'sd8191);
		rd_chk(13'h10D, 8'h39);
		end_test("offset estimate");
		report_and_stop();
	end
endmodule // test_sdc_ctrl
